// ==== logic/ir_command_receiver.sv ====
// biphase infrared command receiver with serial output and analog memories
//
// Implementation choices: the Avalon-MM slave port and the address map.
`default_nettype none
module ir_command_receiver #(
  parameter int HALF_CYC = ir_rx_pkg::HALF_BIT_NS / ir_rx_pkg::CLK_NS,
  parameter int ENV_CYC = ir_rx_pkg::ENV_HOLD_NS / ir_rx_pkg::CLK_NS,
  parameter int REPEAT_CYC = ir_rx_pkg::REPEAT_NS / ir_rx_pkg::CLK_NS
) (
  input wire logic clk_i,                   // 100 MHz clock
  input wire logic rst_i,                   // synchronous power-up reset
  input wire logic ir_input_pin_i,          // carrier bursts, high = light
  input wire logic start_polarity_select_i, // expected start bit
  input wire logic front_sound_control_in_i,// high up, low down
  input wire logic mains_switch_i,          // pin level as seen
  output logic mains_switch_o,              // high = standby
  output logic mains_switch_oe_o,           // drive enable
  input wire logic keyboard_bank_a_i,       // pin level as seen
  output logic keyboard_bank_a_o,           // text bank
  output logic keyboard_bank_a_oe_o,        // drive enable
  input wire logic keyboard_bank_b_i,       // pin level as seen
  output logic keyboard_bank_b_o,           // spare bank
  output logic keyboard_bank_b_oe_o,        // drive enable
  input wire logic spare_toggle_a_i,        // pin level as seen
  output logic spare_toggle_a_o,            // spare toggle a
  output logic spare_toggle_a_oe_o,         // drive enable
  input wire logic spare_toggle_b_i,        // pin level as seen
  output logic spare_toggle_b_o,            // spare toggle b
  output logic spare_toggle_b_oe_o,         // drive enable
  output logic serial_data_o,               // shared serial data line
  output logic tv_strobe_o,                 // tv enable and clock
  output logic caption_strobe_o,            // caption enable and clock
  output logic sound_level_pwm_o,           // volume pwm
  output logic luma_level_pwm_o,            // brightness pwm
  output logic saturation_pwm_o,            // colour saturation pwm
  output logic picture_level_pwm_o,         // contrast pwm
  input wire logic [3:0] avs_address,       // byte address
  input wire logic avs_read,                // read request
  input wire logic avs_write,               // write request
  input wire logic [31:0] avs_writedata,    // write data
  output logic [31:0] avs_readdata,         // read data
  output logic avs_waitrequest              // low for one answer cycle
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] in_meta;
  logic [7:0] in_sync;
  logic ir_prev;
  // meta stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    in_meta <= {spare_toggle_b_i, spare_toggle_a_i, keyboard_bank_b_i,
                keyboard_bank_a_i, mains_switch_i, front_sound_control_in_i,
                start_polarity_select_i, ir_input_pin_i};
    in_sync <= in_meta;
    ir_prev <= in_sync[0];
  end
  wire logic ir_s = in_sync[0];
  wire logic pol_s = in_sync[1];
  wire logic front_s = in_sync[2];
  wire logic [4:0] pin_s = in_sync[7:3];

  // ----------------------------------------------------------------
  // carrier envelope and biphase sampling
  // ----------------------------------------------------------------
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;
  rx_state_e rx_state;
  logic [23:0] env_cnt;
  logic env;
  logic env_prev;
  logic [23:0] slot_tmr;
  logic [3:0] slot;
  logic [13:0] halves;
  logic word_done;
  // a carrier edge retriggers the hold timer, bridging burst gaps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      env_cnt <= '0;
      env <= 1'b0;
      env_prev <= 1'b0;
    end else begin
      if (ir_s && !ir_prev) env_cnt <= 24'(ENV_CYC);
      else if (env_cnt != '0) env_cnt <= env_cnt - 24'h1;
      env <= (env_cnt != '0);
      env_prev <= env;
    end
  end
  // slot 0 presignal, slot 1 gap, slots 2..15 are the seven bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      slot_tmr <= '0;
      slot <= '0;
      halves <= '0;
      word_done <= 1'b0;
    end else begin
      word_done <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          slot_tmr <= '0;
          slot <= '0;
          if (env && !env_prev) rx_state <= RX_FRAME;
        end
        RX_FRAME: begin
          slot_tmr <= slot_tmr + 24'h1;
          if (slot_tmr == 24'(HALF_CYC / 2) && slot >= 4'h2)
            halves <= {halves[12:0], env};
          if (slot_tmr == 24'(HALF_CYC - 1)) begin
            slot_tmr <= '0;
            slot <= slot + 4'h1;
            if (slot == 4'hf) begin
              rx_state <= RX_IDLE;
              word_done <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  // burst-then-gap is a one; equal halves make the word invalid
  function automatic logic [7:0] decode_halves(input logic [13:0] h);
    logic ok;
    logic [6:0] b;
    ok = 1'b1;
    b = '0;
    for (int i = 0; i < 7; i++) begin
      b[6-i] = h[13-2*i];
      if (h[13-2*i] == h[12-2*i]) ok = 1'b0;
    end
    return {ok, b};
  endfunction
  wire logic [7:0] dec = decode_halves(halves);

  logic instr_valid;
  logic [5:0] instr;
  logic reject_seen;
  logic reject_clr;
  // words with the wrong start bit never reach the command logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_valid <= 1'b0;
      instr <= '0;
    end else begin
      instr_valid <= word_done && dec[7] && (dec[6] == pol_s);
      if (word_done && dec[7]) instr <= dec[5:0];
    end
  end
  // sticky flag, a new reject wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) reject_seen <= 1'b0;
    else if (word_done && dec[7] && dec[6] != pol_s) reject_seen <= 1'b1;
    else if (reject_clr) reject_seen <= 1'b0;
  end

  // ----------------------------------------------------------------
  // instruction decode by bank
  // ----------------------------------------------------------------
  logic front_en;
  logic rep_tick;
  logic [23:0] rep_cnt;
  wire logic tv = !keyboard_bank_a_o && !keyboard_bank_b_o;
  wire logic bank_a = keyboard_bank_a_o;
  wire logic tva = tv || bank_a;
  wire logic is_normal = instr_valid && instr == ir_rx_pkg::I_NORMAL && tva;
  wire logic is_quick = instr_valid && instr == ir_rx_pkg::I_QUICK && tva;
  wire logic is_standby = instr_valid && instr == ir_rx_pkg::I_STANDBY;
  wire logic is_spare_a = instr_valid && instr == ir_rx_pkg::I_SPARE_A && tv;
  wire logic is_spare_b = instr_valid && instr == ir_rx_pkg::I_SPARE_B && tv;
  wire logic key_a = instr_valid && instr == ir_rx_pkg::I_BANK_A;
  wire logic key_b = instr_valid && instr == ir_rx_pkg::I_BANK_B;
  wire logic is_digit = instr_valid && tv && instr >= ir_rx_pkg::I_DIGIT_FIRST
                        && instr <= ir_rx_pkg::I_DIGIT_LAST;
  wire logic mains_on = is_digit || (instr_valid && tv
                        && instr >= ir_rx_pkg::I_BANK_A && instr <= ir_rx_pkg::I_ON_LAST);
  wire logic is_ana = instr_valid && tva && instr >= ir_rx_pkg::I_ANA_FIRST
                      && instr <= ir_rx_pkg::I_ANA_LAST;
  wire logic front_step = rep_tick && front_en;
  wire logic vol_up = (is_ana && instr[2:0] == 3'h0) || (front_step && front_s);

  // ----------------------------------------------------------------
  // mains, bank and spare toggles with outside forcing
  // ----------------------------------------------------------------
  logic [1:0] holdoff;
  wire logic [4:0] drv = {spare_toggle_b_o, spare_toggle_a_o, keyboard_bank_b_o,
                          keyboard_bank_a_o, mains_switch_o};
  wire logic adopt = holdoff == 2'h0 && pin_s != drv && !instr_valid;
  wire logic standby_in = is_standby
                          || (adopt && pin_s[ir_rx_pkg::PIN_MAINS] && !mains_switch_o);
  // a fresh drive needs sync time before a mismatch means forcing
  always_ff @(posedge clk_i) begin
    if (rst_i || instr_valid || adopt) holdoff <= 2'(ir_rx_pkg::HOLDOFF_CYC);
    else if (holdoff != 2'h0) holdoff <= holdoff - 2'h1;
  end
  always_ff @(posedge clk_i) begin
    mains_switch_oe_o <= 1'b1;
    keyboard_bank_a_oe_o <= 1'b1;
    keyboard_bank_b_oe_o <= 1'b1;
    spare_toggle_a_oe_o <= 1'b1;
    spare_toggle_b_oe_o <= 1'b1;
  end
  // standby entry overrides everything else in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || standby_in) begin
      mains_switch_o <= 1'b1;
      keyboard_bank_a_o <= 1'b0;
      keyboard_bank_b_o <= 1'b0;
      spare_toggle_a_o <= 1'b1;
      spare_toggle_b_o <= 1'b0;
    end else if (adopt) begin
      mains_switch_o <= pin_s[ir_rx_pkg::PIN_MAINS];
      keyboard_bank_a_o <= pin_s[ir_rx_pkg::PIN_BANK_A];
      keyboard_bank_b_o <= pin_s[ir_rx_pkg::PIN_BANK_B]
                           && !pin_s[ir_rx_pkg::PIN_BANK_A];
      spare_toggle_a_o <= pin_s[ir_rx_pkg::PIN_SPARE_A];
      spare_toggle_b_o <= pin_s[ir_rx_pkg::PIN_SPARE_B];
    end else begin
      if (mains_on) mains_switch_o <= 1'b0;
      if (is_normal) begin
        spare_toggle_a_o <= 1'b1;
        spare_toggle_b_o <= 1'b0;
      end else begin
        if (is_spare_a) spare_toggle_a_o <= !spare_toggle_a_o;
        if (is_spare_b) spare_toggle_b_o <= !spare_toggle_b_o;
      end
      if (key_a) begin
        keyboard_bank_a_o <= !keyboard_bank_a_o;
        if (!keyboard_bank_a_o) keyboard_bank_b_o <= 1'b0;
      end else if (key_b) begin
        keyboard_bank_b_o <= !keyboard_bank_b_o;
        if (!keyboard_bank_b_o) keyboard_bank_a_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // quicktone mute
  // ----------------------------------------------------------------
  logic mute;
  always_ff @(posedge clk_i) begin
    if (rst_i) mute <= 1'b0;
    else if (vol_up || standby_in || mains_switch_o || is_normal || key_a || key_b
             || is_digit) mute <= 1'b0;
    else if (is_quick) mute <= !mute;
  end

  // ----------------------------------------------------------------
  // analog memories and pwm
  // ----------------------------------------------------------------
  logic [5:0] level [4];
  logic [10:0] pwm_tmr;
  logic [5:0] phase;
  // front control repeats at the same rate as held remote keys
  always_ff @(posedge clk_i) begin
    if (rst_i || rep_cnt == 24'(REPEAT_CYC - 1)) rep_cnt <= '0;
    else rep_cnt <= rep_cnt + 24'h1;
    rep_tick <= !rst_i && rep_cnt == 24'(REPEAT_CYC - 1);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || is_normal) begin
      level[0] <= ir_rx_pkg::SOUND_DEFAULT;
      for (int k = 1; k < 4; k++) level[k] <= ir_rx_pkg::PIC_DEFAULT;
    end else if (is_ana) begin
      if (!instr[0] && level[instr[2:1]] != ir_rx_pkg::STEP_MAX)
        level[instr[2:1]] <= level[instr[2:1]] + 6'h1;
      else if (instr[0] && level[instr[2:1]] != 6'h00)
        level[instr[2:1]] <= level[instr[2:1]] - 6'h1;
    end else if (front_step) begin
      if (front_s && level[0] != ir_rx_pkg::STEP_MAX) level[0] <= level[0] + 6'h1;
      else if (!front_s && level[0] != 6'h00) level[0] <= level[0] - 6'h1;
    end
  end
  // one period is sixty ticks, so each stored step is one tick high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_tmr <= '0;
      phase <= '0;
    end else if (pwm_tmr == 11'(ir_rx_pkg::PWM_TICK_CYC - 1)) begin
      pwm_tmr <= '0;
      phase <= (phase == ir_rx_pkg::STEP_MAX - 6'h1) ? 6'h00 : phase + 6'h1;
    end else pwm_tmr <= pwm_tmr + 11'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sound_level_pwm_o <= 1'b0;
      luma_level_pwm_o <= 1'b0;
      saturation_pwm_o <= 1'b0;
      picture_level_pwm_o <= 1'b0;
    end else begin
      sound_level_pwm_o <= !mains_switch_o && !mute && phase < level[0];
      luma_level_pwm_o <= !mains_switch_o && phase < level[1];
      saturation_pwm_o <= !mains_switch_o && phase < level[2];
      picture_level_pwm_o <= !mains_switch_o && phase < level[3];
    end
  end

  // ----------------------------------------------------------------
  // serial output selection and shifter
  // ----------------------------------------------------------------
  logic block;
  logic last_end;
  logic ser_busy;
  logic ser_tv;
  logic [6:0] ser_shift;
  logic [2:0] ser_bits;
  logic [10:0] ser_tmr;
  wire logic is_end = instr == ir_rx_pkg::I_END;
  wire logic go_single = !is_end && instr != ir_rx_pkg::I_STANDBY && !block;
  wire logic send = instr_valid && !ser_busy
                    && (tv || (is_end ? last_end : go_single));
  // busy shifter drops the word; frames are far apart on the ir side
  always_ff @(posedge clk_i) begin
    if (rst_i || standby_in || tv) block <= 1'b0;
    else if (instr_valid && is_end) block <= 1'b0;
    else if (send) block <= 1'b1;
    if (rst_i) last_end <= 1'b0;
    else if (instr_valid) last_end <= is_end;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_busy <= 1'b0;
      ser_tv <= 1'b0;
      ser_shift <= '0;
      ser_bits <= '0;
      ser_tmr <= '0;
      serial_data_o <= 1'b0;
      tv_strobe_o <= 1'b0;
      caption_strobe_o <= 1'b0;
    end else if (send) begin
      ser_busy <= 1'b1;
      ser_tv <= tv;
      ser_shift <= {1'b1, instr};
      ser_bits <= '0;
      ser_tmr <= '0;
    end else if (ser_busy) begin
      ser_tmr <= ser_tmr + 11'h1;
      if (ser_tmr == 11'h0) serial_data_o <= ser_shift[6];
      tv_strobe_o <= ser_tv && ser_tmr >= 11'(ir_rx_pkg::SER_BIT_CYC / 2);
      caption_strobe_o <= ser_tmr >= 11'(ir_rx_pkg::SER_BIT_CYC / 2);
      if (ser_tmr == 11'(ir_rx_pkg::SER_BIT_CYC - 1)) begin
        ser_tmr <= '0;
        ser_shift <= {ser_shift[5:0], 1'b0};
        ser_bits <= ser_bits + 3'h1;
        tv_strobe_o <= 1'b0;
        caption_strobe_o <= 1'b0;
        if (ser_bits == 3'h6) ser_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait state, then one answer cycle
  // ----------------------------------------------------------------
  wire logic take = (avs_read || avs_write) && !avs_waitrequest;
  assign reject_clr = take && avs_write && avs_address == ir_rx_pkg::REG_LAST
                      && avs_writedata[ir_rx_pkg::LAST_REJECT];
  always_ff @(posedge clk_i) begin
    if (rst_i || !avs_waitrequest) avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write) avs_waitrequest <= 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) front_en <= 1'b0;
    else if (take && avs_write && avs_address == ir_rx_pkg::REG_CTRL)
      front_en <= avs_writedata[ir_rx_pkg::CTRL_FRONT_EN];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) avs_readdata <= '0;
    else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        ir_rx_pkg::REG_CTRL: avs_readdata <= {31'h0, front_en};
        ir_rx_pkg::REG_STATUS: avs_readdata <= {24'h0, ser_busy, block, mute, drv};
        ir_rx_pkg::REG_LAST: avs_readdata <= {23'h0, reject_seen, 2'h0, instr};
        ir_rx_pkg::REG_ANALOG:
          avs_readdata <= {2'h0, level[3], 2'h0, level[2], 2'h0, level[1], 2'h0, level[0]};
        default: avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles since a caption-only word started; saturating, so no long delay range is needed
  logic [11:0] quiet_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || (send && tv)) quiet_cnt <= '0;
    else if (send) quiet_cnt <= 12'h1;
    else if (quiet_cnt != '0 && quiet_cnt != 12'hfff) quiet_cnt <= quiet_cnt + 12'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_start_reject_word: assert property (word_done && dec[6] != pol_s |=> !instr_valid)
    else $error("mismatched start bit accepted");
  a_mute_sound_low: assert property (mute |=> !sound_level_pwm_o)
    else $error("sound output high while muted");
  a_standby_analog_low: assert property (mains_switch_o |=> !luma_level_pwm_o
    && !saturation_pwm_o && !picture_level_pwm_o)
    else $error("analog output high in standby");
  a_banks_exclusive: assert property (!(keyboard_bank_a_o && keyboard_bank_b_o))
    else $error("both banks high");
  a_standby_clears_banks: assert property (is_standby |=> mains_switch_o
    && !keyboard_bank_a_o && !keyboard_bank_b_o && !block)
    else $error("standby did not clear state");
  a_normal_sets_levels: assert property (is_normal |=> level[0] == ir_rx_pkg::SOUND_DEFAULT
    && level[1] == ir_rx_pkg::PIC_DEFAULT)
    else $error("normal did not restore levels");
  a_bank_tv_quiet: assert property (quiet_cnt != 12'h0 |-> !tv_strobe_o && !ser_tv)
    else $error("tv strobe active outside tv bank");
  a_digit_mains_on: assert property (is_digit && !standby_in |=> !mains_switch_o)
    else $error("digit did not switch mains on");
  a_single_block: assert property (send && !tv && !is_end |=> block)
    else $error("single mode not blocked after send");
  a_frame_busy: assert property (send |=> ser_busy [*8])
    else $error("serial frame ended early");
endmodule // ir_command_receiver
`default_nettype wire

// ==== logic/ir_rx_pkg.sv ====
// constants shared by the infrared command receiver
`default_nettype none
package ir_rx_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;              // 100 MHz
  localparam int HALF_BIT_NS = 500000;     // one pulse group
  localparam int ENV_HOLD_NS = 100000;     // carrier gap bridging
  localparam int REPEAT_NS = 125000000;    // about 8 Hz
  localparam int PWM_PERIOD_NS = 1000000;  // about 1 kHz
  localparam int SER_BIT_NS = 16000;       // serial bit time
  localparam int SER_BIT_CYC = SER_BIT_NS / CLK_NS;
  localparam int STEPS = 60;
  localparam int PWM_TICK_CYC = PWM_PERIOD_NS / STEPS / CLK_NS;
  localparam int HOLDOFF_CYC = 3;
  // ----------------------------------------------------------------
  // analog memory values
  // ----------------------------------------------------------------
  localparam logic [5:0] STEP_MAX = 6'h3c;
  localparam logic [5:0] SOUND_DEFAULT = 6'h14;  // one third
  localparam logic [5:0] PIC_DEFAULT = 6'h1e;    // one half
  // ----------------------------------------------------------------
  // instruction numbers
  // ----------------------------------------------------------------
  localparam logic [5:0] I_NORMAL = 6'h00;
  localparam logic [5:0] I_QUICK = 6'h01;
  localparam logic [5:0] I_STANDBY = 6'h02;
  localparam logic [5:0] I_SPARE_A = 6'h03;
  localparam logic [5:0] I_BANK_A = 6'h04;
  localparam logic [5:0] I_ON_LAST = 6'h07;
  localparam logic [5:0] I_BANK_B = 6'h06;
  localparam logic [5:0] I_ANA_FIRST = 6'h08;
  localparam logic [5:0] I_ANA_LAST = 6'h0f;
  localparam logic [5:0] I_DIGIT_FIRST = 6'h10;
  localparam logic [5:0] I_DIGIT_LAST = 6'h19;
  localparam logic [5:0] I_SPARE_B = 6'h20;
  localparam logic [5:0] I_END = 6'h3e;
  // ----------------------------------------------------------------
  // register map and pin vector layout
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;
  localparam logic [3:0] REG_ANALOG = 4'hc;
  localparam int CTRL_FRONT_EN = 0;
  localparam int LAST_REJECT = 8;
  localparam int PIN_MAINS = 0;
  localparam int PIN_BANK_A = 1;
  localparam int PIN_BANK_B = 2;
  localparam int PIN_SPARE_A = 3;
  localparam int PIN_SPARE_B = 4;
endpackage
`default_nettype wire

// ==== test/ir_tx_model.sv ====
// remote transmitter model: biphase carrier frames on the receiver input
`default_nettype none
module ir_tx_model #(
  parameter int HALF_CYC = 40
) (
  input wire logic clk_i, // bench clock
  output logic ir_o // carrier out, high = light
);
  timeunit 1ns;
  timeprecision 1ps;
  logic burst = 1'b0;
  logic car = 1'b0;
  // carrier edges every cycle keep the receiver envelope retriggered
  always @(posedge clk_i) car <= ~car;
  assign ir_o = burst & car;
  // presignal, gap, start bit, six bits msb first; a one is burst then gap
  task automatic send(input logic [6:0] w);
    logic [15:0] s;
    s = 16'h8000;
    for (int i = 0; i < 7; i++) begin
      s[13-2*i] = w[6-i];
      s[12-2*i] = ~w[6-i];
    end
    for (int k = 15; k >= 0; k--) begin
      burst <= s[k];
      repeat (HALF_CYC) @(posedge clk_i);
    end
    burst <= 1'b0;
  endtask
endmodule // ir_tx_model
`default_nettype wire

// ==== test/ir_command_receiver_tb_top.sv ====
// self-checking bench for the infrared command receiver
`default_nettype none
module ir_command_receiver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ir, mo, bao, bbo, sao, sbo, sd, tvs, cps, wreq, tvf;
  logic pol = 1'b1;
  logic sp, lp;
  logic fr = 1'b0;
  logic fon = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic cq = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, r;
  logic [6:0] sh;
  logic [5:0] d;
  logic [7:0] expq[$];
  int n_fail = 0, checks = 0, nb = 0, seed = 32'h48da;
  initial forever #5 clk_i = ~clk_i;
  ir_tx_model #(.HALF_CYC(40)) u_tx (.clk_i(clk_i), .ir_o(ir));
  // pins loop back; fon pulls the mains pin low as an outside force would
  ir_command_receiver #(.HALF_CYC(40), .ENV_CYC(8), .REPEAT_CYC(50)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ir_input_pin_i(ir), .start_polarity_select_i(pol),
    .front_sound_control_in_i(fr), .mains_switch_i(mo & !fon), .mains_switch_o(mo),
    .mains_switch_oe_o(), .keyboard_bank_a_i(bao), .keyboard_bank_a_o(bao),
    .keyboard_bank_a_oe_o(), .keyboard_bank_b_i(bbo), .keyboard_bank_b_o(bbo),
    .keyboard_bank_b_oe_o(), .spare_toggle_a_i(sao), .spare_toggle_a_o(sao),
    .spare_toggle_a_oe_o(), .spare_toggle_b_i(sbo), .spare_toggle_b_o(sbo),
    .spare_toggle_b_oe_o(), .serial_data_o(sd), .tv_strobe_o(tvs),
    .caption_strobe_o(cps), .sound_level_pwm_o(sp), .luma_level_pwm_o(lp),
    .saturation_pwm_o(), .picture_level_pwm_o(), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dw);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= dw;
    do @(posedge clk_i); while (wreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  // send a frame, note the expected serial word, wait until the shifter is idle
  task automatic frame(input logic [6:0] w, input logic [7:0] e, input bit q);
    u_tx.send(w);
    if (q) expq.push_back(e);
    repeat (20) @(posedge clk_i);
    do bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0); while (r[7] !== 1'b0);
  endtask
  // caption strobe rises mid-bit with data settled; tv strobe must agree with bank
  always @(posedge clk_i) begin
    cq <= cps;
    if (cps && !cq) begin
      sh = {sh[5:0], sd};
      tvf = tvs;
      nb++;
      if (nb == 7) begin
        nb = 0;
        check({tvf, sh}, expq.size() ? expq.pop_front() : 8'hff);
      end
    end
  end
  initial begin
    #900000;
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r, 32'h9);
    bus(1'b0, ir_rx_pkg::REG_ANALOG, 32'h0);
    check(r, 32'h1e1e1e14);
    d = 6'h10 + 6'($unsigned($random(seed)) % 10);
    frame({1'b1, d}, {2'b11, d}, 1);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[0], 1'b0);
    check(lp, 1'b1);
    frame({1'b1, ir_rx_pkg::I_QUICK}, {2'b11, ir_rx_pkg::I_QUICK}, 1);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[5], 1'b1);
    check(sp, 1'b0);
    fr <= 1'b1;
    bus(1'b1, ir_rx_pkg::REG_CTRL, 32'h1);
    repeat (4000) @(posedge clk_i);
    bus(1'b1, ir_rx_pkg::REG_CTRL, 32'h0);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[5], 1'b0);
    check(sp, 1'b1);
    bus(1'b0, ir_rx_pkg::REG_ANALOG, 32'h0);
    check(r, 32'h1e1e1e3c);
    pol <= 1'b0;
    frame(7'h44, 8'h0, 0);
    bus(1'b0, ir_rx_pkg::REG_LAST, 32'h0);
    check(r[8], 1'b1);
    bus(1'b1, ir_rx_pkg::REG_LAST, 32'h100);
    bus(1'b0, ir_rx_pkg::REG_LAST, 32'h0);
    check(r[8], 1'b0);
    pol <= 1'b1;
    frame({1'b1, ir_rx_pkg::I_BANK_A}, {2'b11, ir_rx_pkg::I_BANK_A}, 1);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[2:1], 2'b01);
    frame(7'h49, 8'h49, 1);
    frame(7'h49, 8'h0, 0);
    frame({1'b1, ir_rx_pkg::I_END}, 8'h0, 0);
    frame({1'b1, ir_rx_pkg::I_END}, {2'b01, ir_rx_pkg::I_END}, 1);
    frame({1'b1, ir_rx_pkg::I_STANDBY}, 8'h0, 0);
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[6:0], 7'h09);
    check(lp, 1'b0);
    bus(1'b0, ir_rx_pkg::REG_ANALOG, 32'h0);
    check(r, 32'h1e1e1e3a);
    fon <= 1'b1;
    repeat (10) @(posedge clk_i);
    fon <= 1'b0;
    bus(1'b0, ir_rx_pkg::REG_STATUS, 32'h0);
    check(r[0], 1'b0);
    check(expq.size(), 0);
    results();
  end
endmodule // ir_command_receiver_tb_top
`default_nettype wire
